// ### bench/host_pins_model.sv
// Host side of the output pins: pull-ups and a floating mirror line
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
  // Clock
  input  wire logic clk_i,
  // Pins from the block
  input  wire logic int_n_i,
  input  wire logic int_oe_i,
  input  wire logic mirror_i,
  input  wire logic mirror_oe_i,
  input  wire logic rst_n_i,
  input  wire logic rst_oe_i,
  // Levels seen by the host
  output var  logic int_pin_o,
  output var  logic mirror_pin_o,
  output var  logic rst_pin_o
);
  logic last_r = 1'b0;
  // A floated mirror line shows the inverse of its last driven level, so a stale read fails
  always @(posedge clk_i) begin
    if (mirror_oe_i) begin
      last_r <= mirror_i;
    end
  end
  assign int_pin_o    = int_oe_i ? int_n_i : 1'b1;
  assign mirror_pin_o = mirror_oe_i ? mirror_i : ~last_r;
  assign rst_pin_o    = rst_oe_i ? rst_n_i : 1'b1;
endmodule
`default_nettype wire

// ### bench/tb_rtc_event_and_reset_outputs.sv
// Self-checking bench for the event and reset output stage
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_event_and_reset_outputs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        sup   = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [5:0]  fl    = 6'h00;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack, int_n, int_oe, mo, moe, rn, roe, irq, ip, mp, rp;
  logic        int_oe2, moe2, rn2, roe2;
  int          fails = 0;
  int          checked = 0;
  int          n;
  always #50 clk_i = ~clk_i;
  // Short release count keeps the run brief
  rtc_event_and_reset_outputs #(.HAS_RST_OUT(1'b1), .RELEASE_CYCLES(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wakeup_timer_flag_i(fl[0]), .alarm_flag_i(fl[1]), .time_update_flag_i(fl[2]),
    .event_flag_i(fl[3]), .temp_comp_stop_flag_i(fl[4]), .voltage_low_flag_i(fl[5]),
    .supply_low_i(sup), .int_n_o(int_n), .int_oe_o(int_oe), .flag_mirror_out_o(mo),
    .flag_mirror_oe_o(moe), .rst_n_o(rn), .rst_oe_o(roe), .irq_o(irq));
  host_pins_model u_host (
    .clk_i(clk_i), .int_n_i(int_n), .int_oe_i(int_oe), .mirror_i(mo),
    .mirror_oe_i(moe), .rst_n_i(rn), .rst_oe_i(roe), .int_pin_o(ip),
    .mirror_pin_o(mp), .rst_pin_o(rp));
  // Second copy without the reset function
  rtc_event_and_reset_outputs #(.HAS_RST_OUT(1'b0), .RELEASE_CYCLES(20)) u_dut_norst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
    .wakeup_timer_flag_i(fl[0]), .alarm_flag_i(fl[1]), .time_update_flag_i(fl[2]),
    .event_flag_i(fl[3]), .temp_comp_stop_flag_i(fl[4]), .voltage_low_flag_i(fl[5]),
    .supply_low_i(sup), .int_n_o(), .int_oe_o(int_oe2), .flag_mirror_out_o(),
    .flag_mirror_oe_o(moe2), .rst_n_o(rn2), .rst_oe_o(roe2), .irq_o());
  task stop_test;
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask
  task wait_rel(input int lim);
    n = 0;
    while (rp !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (rp !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask
  task t_safe_start;
    tick(2);
    chk("safe pins", {rp, int_oe, moe}, 3'b000);
    chk("no reset fn", {roe2, rn2, moe2}, 3'b101);
    wait_rel(40);
    chk("release delay", n >= 15 && n <= 25, 1);
  endtask
  task t_bus;
    wb(1'b1, 8'h00, 32'h1FF);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h1FF);
    tick(1);
    chk("idle data", rdat, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task t_int_or;
    int idx[4] = '{0, 2, 1, 3};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h00, 32'h1 << i);
      fl <= 6'h01 << idx[i];
      tick(3);
      chk("int on", {ip, int_n, int_oe}, 3'b001);
      wb(1'b1, 8'h00, ~(32'h1 << i) & 32'hF);
      tick(3);
      chk("int off", {ip, int_oe}, 2'b10);
    end
    fl <= 6'h00;
  endtask
  task t_mirror;
    for (int s = 0; s < 6; s++) begin
      for (int p = 0; p < 2; p++) begin
        wb(1'b1, 8'h00, (p << 7) | (s << 4));
        fl <= 6'h01 << s;
        tick(3);
        chk("mirror set", {moe, mp}, {1'b1, p == 0});
        fl <= ~(6'h01 << s);
        tick(3);
        chk("mirror clr", mp, p == 1);
      end
    end
  endtask
  task t_drop;
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    fl <= 6'h09;
    sup <= 1'b1;
    tick(7);
    chk("drop", {rp, int_oe, moe, irq}, 4'b0001);
    chk("no reset fn drop", {roe2, int_oe2, moe2}, 3'b111);
    wb(1'b0, 8'h04, 32'h0);
    chk("event in safe", {q[8], q[3]}, 2'b11);
    wb(1'b0, 8'h08, 32'h0);
    chk("drop status", q[0], 1'b1);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    sup <= 1'b0;
    tick(10);
    sup <= 1'b1;
    tick(3);
    sup <= 1'b0;
    tick(18);
    chk("hold", rp, 1'b0);
    wait_rel(12);
    tick(3);
    chk("int back", ip, 1'b0);
    wb(1'b0, 8'h08, 32'h0);
    chk("status all", q, 32'h7);
    wb(1'b0, 8'h0C, 32'h0);
    chk("mask", q, 32'h1);
  endtask
  task t_keep;
    wb(1'b1, 8'h00, 32'h109);
    sup <= 1'b1;
    tick(7);
    chk("keep", {rp, ip, moe}, 3'b001);
    sup <= 1'b0;
    wait_rel(40);
  endtask
  initial begin
    tick(5);
    rst_i <= 1'b0;
    t_safe_start();
    t_bus();
    t_int_or();
    t_mirror();
    t_drop();
    t_keep();
    stop_test();
  end
endmodule
`default_nettype wire

// ### hdl/rst_release_timer.sv
// Reset output hold timer: asserted on supply drop, released a fixed delay after recovery
`timescale 1ns/1ps
`default_nettype none
module rst_release_timer #(
  parameter int RELEASE_CYCLES = rtc_out_pkg::RELEASE_CYCLES,
  parameter int CNT_W          = $clog2(RELEASE_CYCLES + 1)
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Synchronised supply-low level
  input  wire logic drop_i,
  // Reset output request
  output var  logic active_o
);
  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] cnt;
  } tmr_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(RELEASE_CYCLES - 1);

  tmr_t s_r;
  tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (drop_i) begin
      s_nxt.active = 1'b1;
      s_nxt.cnt    = '0;
    end else if (s_r.active) begin
      if (s_r.cnt == LAST) begin
        s_nxt.active = 1'b0;
        s_nxt.cnt    = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
    end
  end

  // Power-on starts in the asserted state and times out like a recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{active: 1'b1, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active_o = s_r.active;
endmodule
`default_nettype wire

// ### hdl/rtc_event_and_reset_outputs.sv
// Interrupt, flag mirror and reset output stage with a Wishbone register slave
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The interrupt output is asserted while any enabled source among timer, update, alarm and event is active, except in safe mode with keep clear.
// - The interrupt pin is open drain, only ever pulling low and otherwise released.
// - A polarity setting makes the mirrored flag appear true or inverted.
// - Where the reset function exists, a supply drop asserts the open-drain reset output low.
// - After supply recovery the reset output stays asserted 60 ms more and is then released.
// - Where the reset function is absent, the reset position is driven low all the time.
// - Safe mode is the state with the reset output asserted, and event inputs keep working in it.
module rtc_event_and_reset_outputs #(
  parameter bit HAS_RST_OUT    = 1'b1,
  parameter int RELEASE_CYCLES = rtc_out_pkg::RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Internal flags
  input  wire logic        wakeup_timer_flag_i,
  input  wire logic        alarm_flag_i,
  input  wire logic        time_update_flag_i,
  input  wire logic        event_flag_i,
  input  wire logic        temp_comp_stop_flag_i,
  input  wire logic        voltage_low_flag_i,
  // Supply detector, asynchronous
  input  wire logic        supply_low_i,
  // Interrupt pin, open drain
  output var  logic        int_n_o,
  output var  logic        int_oe_o,
  // Flag mirror pin
  output var  logic        flag_mirror_out_o,
  output var  logic        flag_mirror_oe_o,
  // Reset pin, open drain
  output var  logic        rst_n_o,
  output var  logic        rst_oe_o,
  // Processor interrupt
  output var  logic        irq_o
);
  typedef struct packed {
    logic        sup_m;
    logic        sup_s;
    logic        sup_d;
    logic        act_d;
    logic [3:0]  int_en;
    logic [2:0]  sel;
    logic        pol;
    logic        keep;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic        ack;
    logic [31:0] dat;
    logic        int_oe;
    logic        mir;
    logic        mir_oe;
    logic        rst_oe;
    logic        irq;
  } out_st_t;

  out_st_t s_r;
  out_st_t s_nxt;

  logic       rel_active;
  logic       safe;
  logic       safe_hiz;
  logic       int_on;
  logic       sel_flag;
  logic [3:0] int_src;
  logic [5:0] flags;

  assign flags   = {voltage_low_flag_i, temp_comp_stop_flag_i, event_flag_i,
                    time_update_flag_i, alarm_flag_i, wakeup_timer_flag_i};
  assign int_src = {event_flag_i, alarm_flag_i, time_update_flag_i, wakeup_timer_flag_i};

  rst_release_timer #(
    .RELEASE_CYCLES (RELEASE_CYCLES)
  ) u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .drop_i   (s_r.sup_s),
    .active_o (rel_active)
  );

  // Event inputs are not gated by safe mode, so time stamps still land
  assign safe     = HAS_RST_OUT && rel_active;
  assign safe_hiz = safe && !s_r.keep;
  assign int_on   = |(int_src & s_r.int_en);

  always_comb begin
    case (s_r.sel)
      rtc_out_pkg::SEL_TIMER:  sel_flag = flags[0];
      rtc_out_pkg::SEL_ALARM:  sel_flag = flags[1];
      rtc_out_pkg::SEL_UPDATE: sel_flag = flags[2];
      rtc_out_pkg::SEL_EVENT:  sel_flag = flags[3];
      rtc_out_pkg::SEL_TEMP:   sel_flag = flags[4];
      rtc_out_pkg::SEL_VLOW:   sel_flag = flags[5];
      default:                 sel_flag = 1'b0;
    endcase
  end

  always_comb begin
    logic       req;
    logic       rd_clr;
    logic [2:0] ev;
    req    = 1'b0;
    rd_clr = 1'b0;
    ev     = 3'h0;
    s_nxt  = s_r;
    // Supply-low level crosses in through two flops
    s_nxt.sup_m = supply_low_i;
    s_nxt.sup_s = s_r.sup_m;
    s_nxt.sup_d = s_r.sup_s;
    s_nxt.act_d = rel_active;
    // Single-wait-state slave: ack follows the request by one edge
    req       = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = req;
    s_nxt.dat = 32'h0000_0000;
    if (req && wb_we_i) begin
      if (wb_adr_i == rtc_out_pkg::OFF_CTRL) begin
        if (wb_sel_i[0]) begin
          s_nxt.int_en = wb_dat_i[rtc_out_pkg::CTRL_INT_EN_LSB +: 4];
          s_nxt.sel    = wb_dat_i[rtc_out_pkg::CTRL_SEL_LSB +: 3];
          s_nxt.pol    = wb_dat_i[rtc_out_pkg::CTRL_POL_BIT];
        end
        if (wb_sel_i[1]) begin
          s_nxt.keep = wb_dat_i[rtc_out_pkg::CTRL_KEEP_BIT];
        end
      end else if (wb_adr_i == rtc_out_pkg::OFF_IRQ_MASK && wb_sel_i[0]) begin
        s_nxt.imask = wb_dat_i[2:0];
      end
    end else if (req) begin
      if (wb_adr_i == rtc_out_pkg::OFF_CTRL) begin
        s_nxt.dat[rtc_out_pkg::CTRL_INT_EN_LSB +: 4] = s_r.int_en;
        s_nxt.dat[rtc_out_pkg::CTRL_SEL_LSB +: 3]    = s_r.sel;
        s_nxt.dat[rtc_out_pkg::CTRL_POL_BIT]         = s_r.pol;
        s_nxt.dat[rtc_out_pkg::CTRL_KEEP_BIT]        = s_r.keep;
      end else if (wb_adr_i == rtc_out_pkg::OFF_FLAGS) begin
        s_nxt.dat[5:0]                       = flags;
        s_nxt.dat[rtc_out_pkg::FLG_SAFE_BIT] = safe;
        s_nxt.dat[rtc_out_pkg::FLG_INT_BIT]  = s_r.int_oe;
        s_nxt.dat[rtc_out_pkg::FLG_LOW_BIT]  = s_r.sup_s;
      end else if (wb_adr_i == rtc_out_pkg::OFF_IRQ_STAT) begin
        s_nxt.dat[2:0] = s_r.ist;
        rd_clr         = 1'b1;
      end else if (wb_adr_i == rtc_out_pkg::OFF_IRQ_MASK) begin
        s_nxt.dat[2:0] = s_r.imask;
      end
    end
    // Pins
    s_nxt.int_oe = int_on && !safe_hiz;
    s_nxt.mir    = sel_flag ^ s_r.pol;
    s_nxt.mir_oe = !safe_hiz;
    s_nxt.rst_oe = HAS_RST_OUT ? rel_active : 1'b1;
    // Sticky events; a new event beats the clearing read
    ev[rtc_out_pkg::IRQ_DROP]    = s_r.sup_s && !s_r.sup_d;
    ev[rtc_out_pkg::IRQ_RELEASE] = s_r.act_d && !rel_active;
    ev[rtc_out_pkg::IRQ_INT]     = s_nxt.int_oe && !s_r.int_oe;
    s_nxt.ist = (rd_clr ? 3'h0 : s_r.ist) | ev;
    s_nxt.irq = |(s_nxt.ist & s_r.imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.int_en <= rtc_out_pkg::RST_INT_EN;
      s_r.sel    <= rtc_out_pkg::RST_SEL;
      s_r.pol    <= rtc_out_pkg::RST_POL;
      s_r.keep   <= rtc_out_pkg::RST_KEEP;
      s_r.imask  <= rtc_out_pkg::RST_IMASK;
      s_r.act_d  <= 1'b1;
      s_r.rst_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Both open-drain pins only ever drive a low level
  assign int_n_o           = 1'b0;
  assign rst_n_o           = 1'b0;
  assign int_oe_o          = s_r.int_oe;
  assign flag_mirror_out_o = s_r.mir;
  assign flag_mirror_oe_o  = s_r.mir_oe;
  assign rst_oe_o          = s_r.rst_oe;
  assign irq_o             = s_r.irq;
  assign wb_ack_o          = s_r.ack;
  assign wb_dat_o          = s_r.dat;

  // Checks
  logic [31:0] rel_chk_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || s_r.sup_s || !rel_active) begin
      rel_chk_r <= 32'h0000_0000;
    end else begin
      rel_chk_r <= rel_chk_r + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence drop_seen_s;
    supply_low_i [*3];
  endsequence

  sequence rst_low_s;
    ##1 rst_oe_o && !rst_n_o;
  endsequence

  a_int_source_or: assert property ((int_on && !safe_hiz) |=> int_oe_o)
    else $error("enabled source did not assert interrupt");
  a_int_released: assert property (!int_on |=> !int_oe_o && !int_n_o)
    else $error("interrupt pin not released or driven high");
  a_safe_float: assert property (safe_hiz |=> !int_oe_o && !flag_mirror_oe_o)
    else $error("outputs driven in safe mode without keep");
  a_mirror_select: assert property ((s_r.sel == rtc_out_pkg::SEL_EVENT && !s_r.pol)
    |=> flag_mirror_out_o == $past(event_flag_i))
    else $error("mirror does not follow selected flag");
  a_mirror_polarity: assert property ((s_r.sel <= rtc_out_pkg::SEL_VLOW)
    |=> flag_mirror_out_o == ($past(sel_flag) ^ $past(s_r.pol)))
    else $error("mirror polarity wrong");
  a_drop_asserts: assert property (disable iff (rst_i || !HAS_RST_OUT)
    drop_seen_s |=> rst_low_s)
    else $error("supply drop did not assert reset");
  a_release_delay: assert property (disable iff (rst_i || !HAS_RST_OUT)
    $fell(rel_active) |-> rel_chk_r == RELEASE_CYCLES)
    else $error("reset released at wrong time");
  a_no_rst_fn: assert property (disable iff (rst_i || HAS_RST_OUT)
    rst_oe_o && !rst_n_o)
    else $error("reset position not held low");
  a_event_in_safe: assert property ((safe && s_r.keep && event_flag_i
    && s_r.int_en[rtc_out_pkg::EN_EVENT]) |=> int_oe_o)
    else $error("event lost in safe mode");
  a_drop_restarts: assert property (s_r.sup_s |=> rel_active && rel_chk_r == 32'h0000_0000)
    else $error("release counter not restarted");
endmodule
`default_nettype wire

// ### hdl/rtc_out_pkg.sv
// Constants shared by the event and reset output stage
package rtc_out_pkg;
  // Timing
  localparam int CLK_FREQ_HZ      = 10_000_000;
  localparam int RELEASE_TIME_MS  = 60;
  localparam int RELEASE_CYCLES   = RELEASE_TIME_MS * (CLK_FREQ_HZ / 1000);
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_FLAGS    = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  // Control register fields
  localparam int CTRL_INT_EN_LSB = 0;
  localparam int CTRL_SEL_LSB    = 4;
  localparam int CTRL_POL_BIT    = 7;
  localparam int CTRL_KEEP_BIT   = 8;
  // Interrupt enable bit positions
  localparam int EN_TIMER  = 0;
  localparam int EN_UPDATE = 1;
  localparam int EN_ALARM  = 2;
  localparam int EN_EVENT  = 3;
  // Flag select codes
  localparam logic [2:0] SEL_TIMER   = 3'h0;
  localparam logic [2:0] SEL_ALARM   = 3'h1;
  localparam logic [2:0] SEL_UPDATE  = 3'h2;
  localparam logic [2:0] SEL_EVENT   = 3'h3;
  localparam logic [2:0] SEL_TEMP    = 3'h4;
  localparam logic [2:0] SEL_VLOW    = 3'h5;
  // Flags register fields
  localparam int FLG_SAFE_BIT = 8;
  localparam int FLG_INT_BIT  = 9;
  localparam int FLG_LOW_BIT  = 10;
  // Status / mask bits
  localparam int IRQ_DROP    = 0;
  localparam int IRQ_RELEASE = 1;
  localparam int IRQ_INT     = 2;
  // Reset values
  localparam logic [3:0] RST_INT_EN = 4'h0;
  localparam logic [2:0] RST_SEL    = 3'h0;
  localparam logic       RST_POL    = 1'b0;
  localparam logic       RST_KEEP   = 1'b0;
  localparam logic [2:0] RST_IMASK  = 3'h0;
endpackage
